// ===== hdl/ipn_defines.svh
// constants for the in-band parameter negotiation engine
`ifndef IPN_DEFINES_SVH
`define IPN_DEFINES_SVH
// wishbone register byte offsets
`define IPN_REG_CTRL      4'h0
`define IPN_REG_STATUS    4'h4
`define IPN_REG_PARAM_LO  4'h8
`define IPN_REG_PARAM_HI  4'hC
// control bit positions
`define IPN_CTRL_GO       0
`define IPN_CTRL_CALLING  1
`define IPN_CTRL_ACCEPT   2
`define IPN_CTRL_REENTER  3
`define IPN_CTRL_DISC     4
`define IPN_CTRL_NEWRATE  5
`define IPN_CTRL_UPKEEP   6
`define IPN_CTRL_NOREENT  7
// octet codings
`define IPN_OCT_XBEGIN    8'hE6
`define IPN_OCT_VERSION   8'hEA
`define IPN_OCT_SET0      8'hE0
`define IPN_OCT_UPKEEP    8'hEE
`define IPN_OCT_READY     8'hFA
`define IPN_OCT_IDLE      8'hFE
`define IPN_OCT_INACT     8'hFF
`define IPN_OCT_FILL      8'hFB
`define IPN_OCT_LOW       8'hA0
`define IPN_OCT_HIGH      8'hB0
// repetition counts
`define IPN_CMD_REPEAT    6'd32
`define IPN_PAIR_REPEAT   2'd3
`define IPN_VERIFY_RUN    6'd4
// timers in ms, cycles at 10 MHz (100 ns)
`define IPN_CLK_NS        100
`define IPN_T1_MS         10
`define IPN_T2_MS         5
`define IPN_T1_CYC        ((`IPN_T1_MS * 1000000) / `IPN_CLK_NS)
`define IPN_T2_CYC        ((`IPN_T2_MS * 1000000) / `IPN_CLK_NS)
`endif

// ===== hdl/ipn_pkg.sv
// types for the in-band parameter negotiation engine
package ipn_pkg;
  typedef enum logic [3:0] {
    IPN_IDLE    = 4'b0000,
    IPN_XBEGIN  = 4'b0001,
    IPN_WAITX   = 4'b0010,
    IPN_SEND    = 4'b0011,
    IPN_FILL    = 4'b0100,
    IPN_READY   = 4'b0101,
    IPN_RESYNC  = 4'b0110,
    IPN_NOEXCH  = 4'b0111,
    IPN_DATA    = 4'b1000,
    IPN_REENT   = 4'b1001,
    IPN_CLEAR   = 4'b1010
  } ipn_state_e;
  typedef logic [7:0] ipn_octet_t;
endpackage

// ===== hdl/ipn_rx_if.sv
// octet verification results passed from checker to controller
`timescale 1ns/1ps
interface ipn_rx_if;
  logic [7:0] cmd;
  logic       cmd_valid;
  modport chk (output cmd, output cmd_valid);
  modport ctl (input cmd, input cmd_valid);
endinterface

// ===== hdl/ipn_verify.sv
// persistence checker for received command and status octets
`timescale 1ns/1ps
`include "ipn_defines.svh"
module ipn_verify
  import ipn_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic [7:0] octet_in,
  input  wire logic       octet_stb_in,
  ipn_rx_if.chk           rx
);
  logic [7:0] last_r;
  logic [5:0] run_r;
  // count identical octets, restart on difference
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      last_r       <= 8'h00;
      run_r        <= 6'd0;
      rx.cmd       <= 8'h00;
      rx.cmd_valid <= 1'b0;
    end else begin
      rx.cmd_valid <= 1'b0;
      if (octet_stb_in) begin
        last_r <= octet_in;
        if (octet_in != last_r) begin
          run_r <= 6'd1;
        end else if (run_r != 6'h3F) begin
          run_r <= run_r + 6'd1;
          if (run_r + 6'd1 == `IPN_VERIFY_RUN && octet_in[7] && octet_in[6]) begin
            rx.cmd       <= octet_in;
            rx.cmd_valid <= 1'b1;
          end
        end
      end
    end
  end
  verify_once_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    rx.cmd_valid |=> !rx.cmd_valid) else $error("verified pulse too long");
endmodule // ipn_verify

// ===== hdl/ipn_tx_seq.sv
// octet sequencer for command runs and tripled data pairs
`timescale 1ns/1ps
`include "ipn_defines.svh"
module ipn_tx_seq
  import ipn_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       start_in,
  input  wire logic [7:0] cmd_in,
  input  wire logic [7:0] data_in,
  input  wire logic       has_data_in,
  input  wire logic       take_in,
  output logic [7:0]      octet_out,
  output logic            done_out
);
  logic [5:0] cnt_r;
  logic [1:0] pair_r;
  logic       half_r;
  logic       busy_r;
  logic       data_r;
  logic [7:0] oct_r;
  logic [7:0] oct_nxt;
  // octet on the wire after this edge, so the parent's output register moves in step with each take
  always_comb begin
    oct_nxt = oct_r;
    if (start_in) begin
      oct_nxt = cmd_in;
    end else if (busy_r && take_in) begin
      if (!data_r) begin
        if (cnt_r == `IPN_CMD_REPEAT - 6'd1) begin
          oct_nxt = has_data_in ? (`IPN_OCT_LOW | {4'h0, data_in[3:0]}) : `IPN_OCT_INACT;
        end
      end else if (!half_r) begin
        oct_nxt = `IPN_OCT_HIGH | {4'h0, data_in[7:4]};
      end else if (pair_r == `IPN_PAIR_REPEAT - 2'd1) begin
        oct_nxt = `IPN_OCT_INACT; // no stale high octet between groups
      end else begin
        oct_nxt = `IPN_OCT_LOW | {4'h0, data_in[3:0]};
      end
    end
  end
  assign octet_out = oct_nxt;
  // run of commands then three low-high pairs
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      cnt_r <= 6'd0; pair_r <= 2'd0; half_r <= 1'b0;
      busy_r <= 1'b0; data_r <= 1'b0; done_out <= 1'b0;
      oct_r <= `IPN_OCT_INACT;
    end else begin
      done_out <= 1'b0;
      oct_r    <= oct_nxt;
      if (start_in) begin
        busy_r <= 1'b1; cnt_r <= 6'd0; pair_r <= 2'd0;
        half_r <= 1'b0; data_r <= 1'b0;
      end else if (busy_r && take_in) begin
        if (!data_r) begin
          if (cnt_r == `IPN_CMD_REPEAT - 6'd1) begin
            if (has_data_in) begin
              data_r <= 1'b1;
            end else begin
              busy_r <= 1'b0; done_out <= 1'b1;
            end
          end else begin
            cnt_r <= cnt_r + 6'd1;
          end
        end else if (!half_r) begin
          half_r <= 1'b1;
        end else if (pair_r == `IPN_PAIR_REPEAT - 2'd1) begin
          busy_r <= 1'b0; done_out <= 1'b1;
        end else begin
          half_r <= 1'b0; pair_r <= pair_r + 2'd1;
        end
      end
    end
  end
  low_first_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (busy_r && data_r && take_in && !half_r) |=> oct_r[4]) else $error("high not after low");
endmodule // ipn_tx_seq

// ===== hdl/ipn_ctrl.sv
// negotiation controller driving the peer adaptor link from wishbone registers
//
// The placing of the registers and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "ipn_defines.svh"
module ipn_ctrl
  import ipn_pkg::*;
#(
  parameter int T1_CYC = `IPN_T1_CYC,
  parameter int T2_CYC = `IPN_T2_CYC
) (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [3:0]  wb_adr_in,
  input  wire logic [31:0] wb_dat_in,
  input  wire logic [3:0]  wb_sel_in,
  output logic [31:0]      wb_dat_out,
  output logic             wb_ack_out,
  input  wire logic [7:0]  link_octet_in,
  input  wire logic        link_octet_stb_in,
  input  wire logic        link_take_in,
  input  wire logic        link_sync_in,
  input  wire logic        link_s_on_in,
  input  wire logic        link_x_on_in,
  output logic [7:0]       link_octet_out,
  output logic             link_s_on_out,
  output logic             link_x_on_out,
  output logic             link_clear_out,
  output logic             link_default_out
);
  ipn_rx_if rx ();
  ipn_state_e state_r;
  logic [7:0]  ctrl_r;
  logic [31:0] plo_r, phi_r;
  logic        orig_r, reentry_r, fail_r, compat_r, restart_r;
  logic        vseen_r;
  logic [2:0]  grp_r;
  logic        seq_start_r;
  logic [7:0]  seq_cmd, seq_data, seq_oct;
  logic        seq_has, seq_done;
  logic [31:0] t1_r, t2_r;
  logic        t1_on_r, t2_on_r;
  logic        wb_hit;

  // command verification
  ipn_verify u_verify (
    .clk_in       (clk_in),
    .rst_n_in     (rst_n_in),
    .octet_in     (link_octet_in),
    .octet_stb_in (link_octet_stb_in),
    .rx           (rx.chk)
  );

  // group octet selection: version, five setting groups, upkeep
  always_comb begin
    seq_cmd  = `IPN_OCT_XBEGIN;
    seq_data = 8'h00;
    seq_has  = 1'b1;
    case (grp_r)
      3'd0:    begin seq_cmd = `IPN_OCT_VERSION; seq_data = plo_r[7:0]; end
      3'd6:    begin seq_cmd = `IPN_OCT_UPKEEP; seq_data = phi_r[15:8]; end
      3'd7:    begin seq_cmd = `IPN_OCT_XBEGIN; seq_has = 1'b0; end
      default: begin
        seq_cmd  = `IPN_OCT_SET0 | {4'h0, 1'b0, grp_r - 3'd1};
        seq_data = (grp_r == 3'd1) ? {plo_r[15:14], ctrl_r[`IPN_CTRL_UPKEEP], plo_r[12:8]}
                 : (grp_r == 3'd2) ? plo_r[23:16]
                 : (grp_r == 3'd3) ? plo_r[31:24]
                 : (grp_r == 3'd4) ? phi_r[7:0] : phi_r[7:0] ^ phi_r[23:16];
      end
    endcase
  end

  // transmit sequencer
  ipn_tx_seq u_seq (
    .clk_in      (clk_in),
    .rst_n_in    (rst_n_in),
    .start_in    (seq_start_r),
    .cmd_in      (seq_cmd),
    .data_in     (seq_data),
    .has_data_in (seq_has),
    .take_in     (link_take_in),
    .octet_out   (seq_oct),
    .done_out    (seq_done)
  );

  // wishbone slave, one wait state
  assign wb_hit = wb_cyc_in && wb_stb_in && !wb_ack_out;
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0000_0000;
      ctrl_r     <= 8'h00;
      plo_r      <= 32'h0000_0000;
      phi_r      <= 32'h0000_0000;
    end else begin
      wb_ack_out <= wb_hit;
      ctrl_r[`IPN_CTRL_GO]      <= 1'b0;
      ctrl_r[`IPN_CTRL_REENTER] <= 1'b0;
      ctrl_r[`IPN_CTRL_NEWRATE] <= ctrl_r[`IPN_CTRL_NEWRATE];
      if (wb_hit && wb_we_in && wb_sel_in[0]) begin
        case (wb_adr_in)
          `IPN_REG_CTRL:     ctrl_r <= wb_dat_in[7:0];
          `IPN_REG_PARAM_LO: plo_r  <= wb_dat_in;
          `IPN_REG_PARAM_HI: phi_r  <= wb_dat_in;
          default:           ;
        endcase
      end
      case (wb_adr_in)
        `IPN_REG_CTRL:     wb_dat_out <= {24'h0, ctrl_r};
        `IPN_REG_STATUS:   wb_dat_out <= {16'h0, rx.cmd, fail_r, reentry_r, orig_r, 1'b0, state_r};
        `IPN_REG_PARAM_LO: wb_dat_out <= plo_r;
        `IPN_REG_PARAM_HI: wb_dat_out <= phi_r;
        default:           wb_dat_out <= 32'h0000_0000;
      endcase
    end
  end

  // negotiation and block timers
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || state_r == IPN_IDLE) begin
      t1_r <= 32'd0; t2_r <= 32'd0;
    end else begin
      if (t1_on_r && t1_r != T1_CYC[31:0]) t1_r <= t1_r + 32'd1;
      if (t2_on_r && t2_r != T2_CYC[31:0]) t2_r <= t2_r + 32'd1;
    end
  end

  // peer version seen while our begin run is still going; the run is finished first
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || state_r != IPN_XBEGIN) begin
      vseen_r <= 1'b0;
    end else if (rx.cmd_valid && rx.cmd == `IPN_OCT_VERSION) begin
      vseen_r <= 1'b1;
    end
  end

  // negotiation state machine
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state_r <= IPN_IDLE; orig_r <= 1'b0; reentry_r <= 1'b0;
      fail_r <= 1'b0; grp_r <= 3'd7; seq_start_r <= 1'b0;
      t1_on_r <= 1'b0; t2_on_r <= 1'b0; restart_r <= 1'b0; compat_r <= 1'b0;
    end else begin
      seq_start_r <= 1'b0;
      if (ctrl_r[`IPN_CTRL_DISC]) begin
        state_r <= IPN_CLEAR;
      end else if (t1_on_r && t1_r == T1_CYC[31:0] && state_r != IPN_DATA) begin
        state_r <= IPN_DATA; t1_on_r <= 1'b0;
      end else if (t2_on_r && t2_r == T2_CYC[31:0] && state_r != IPN_DATA) begin
        state_r <= IPN_DATA; t2_on_r <= 1'b0;
      end else begin
        case (state_r)
          IPN_IDLE: if (ctrl_r[`IPN_CTRL_GO]) begin
            reentry_r <= 1'b0; t2_on_r <= 1'b1;
            orig_r <= ctrl_r[`IPN_CTRL_CALLING];
            if (ctrl_r[`IPN_CTRL_CALLING]) begin
              state_r <= IPN_XBEGIN; grp_r <= 3'd7; seq_start_r <= 1'b1; t1_on_r <= 1'b1;
            end else state_r <= IPN_WAITX;
          end
          IPN_XBEGIN: if (seq_done && vseen_r) begin
            state_r <= IPN_SEND; grp_r <= 3'd0; seq_start_r <= 1'b1;
          end else if (seq_done) seq_start_r <= 1'b1;
          IPN_WAITX: if (link_s_on_in && link_x_on_in) state_r <= IPN_DATA;
            else if (rx.cmd_valid && rx.cmd == `IPN_OCT_XBEGIN) begin
              state_r <= IPN_SEND; grp_r <= 3'd0; seq_start_r <= 1'b1; t1_on_r <= 1'b1;
            end
          IPN_SEND: if (seq_done) begin
            if (grp_r == 3'd5 && !ctrl_r[`IPN_CTRL_UPKEEP]) state_r <= IPN_FILL;
            else if (grp_r == 3'd6) state_r <= IPN_FILL;
            else begin grp_r <= grp_r + 3'd1; seq_start_r <= 1'b1; end
          end
          IPN_FILL: begin
            if (restart_r || (rx.cmd_valid && rx.cmd == `IPN_OCT_XBEGIN && !orig_r)) begin
              restart_r <= 1'b0; orig_r <= 1'b1;
              state_r <= IPN_XBEGIN; grp_r <= 3'd7; seq_start_r <= 1'b1;
            end else if (orig_r && rx.cmd_valid && rx.cmd == `IPN_OCT_READY) begin
              reentry_r <= 1'b1;
              state_r <= ctrl_r[`IPN_CTRL_NEWRATE] ? IPN_RESYNC : IPN_DATA;
            end else if (!orig_r && rx.cmd_valid && rx.cmd == `IPN_OCT_FILL) begin
              compat_r <= ctrl_r[`IPN_CTRL_ACCEPT];
              if (ctrl_r[`IPN_CTRL_ACCEPT]) begin
                state_r <= IPN_READY; grp_r <= 3'd7;
              end else if (plo_r[7:4] == 4'h0) begin
                fail_r <= 1'b1; state_r <= IPN_CLEAR;
              end else begin
                orig_r <= 1'b1; state_r <= IPN_XBEGIN; grp_r <= 3'd7; seq_start_r <= 1'b1;
              end
            end
          end
          IPN_READY: if (link_take_in) begin
            reentry_r <= 1'b1; t1_on_r <= 1'b0; t2_on_r <= 1'b0;
            state_r <= ctrl_r[`IPN_CTRL_NEWRATE] ? IPN_RESYNC : IPN_DATA;
          end
          IPN_RESYNC: if (link_sync_in) begin
            if (link_s_on_in && link_x_on_in) state_r <= IPN_DATA;
            else if (!link_s_on_in && !link_x_on_in) state_r <= IPN_NOEXCH;
          end
          IPN_NOEXCH: if (link_s_on_in && link_x_on_in) state_r <= IPN_DATA;
          IPN_DATA: begin
            t1_on_r <= 1'b0; t2_on_r <= 1'b0;
            if (ctrl_r[`IPN_CTRL_REENTER] && reentry_r && !ctrl_r[`IPN_CTRL_NOREENT] && orig_r)
              state_r <= IPN_REENT;
            else if (!link_s_on_in && link_x_on_in && rx.cmd == `IPN_OCT_IDLE) begin
              state_r <= IPN_WAITX; orig_r <= 1'b0;
            end
          end
          IPN_REENT: if (!link_s_on_in && link_x_on_in && rx.cmd == `IPN_OCT_IDLE) begin
            state_r <= IPN_XBEGIN; grp_r <= 3'd7; seq_start_r <= 1'b1; t1_on_r <= 1'b1;
          end
          IPN_CLEAR: if (ctrl_r[`IPN_CTRL_GO]) state_r <= IPN_IDLE;
          default: state_r <= IPN_IDLE;
        endcase
        // sync loss after the case so a set beats the clear in the same cycle
        if (!link_sync_in && state_r != IPN_IDLE && state_r != IPN_DATA) restart_r <= 1'b1;
      end
    end
  end

  // link outputs
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      link_octet_out <= 8'hFF; link_s_on_out <= 1'b0; link_x_on_out <= 1'b0;
      link_clear_out <= 1'b0; link_default_out <= 1'b0;
    end else begin
      link_clear_out   <= (state_r == IPN_CLEAR);
      link_default_out <= (state_r == IPN_DATA) && !compat_r && !reentry_r;
      link_s_on_out    <= (state_r == IPN_DATA) || (state_r == IPN_NOEXCH);
      link_x_on_out    <= (state_r != IPN_RESYNC) && (state_r != IPN_IDLE);
      case (state_r)
        IPN_XBEGIN, IPN_SEND: link_octet_out <= seq_oct;
        IPN_FILL:             link_octet_out <= `IPN_OCT_FILL;
        IPN_READY:            link_octet_out <= `IPN_OCT_READY;
        IPN_REENT:            link_octet_out <= `IPN_OCT_IDLE;
        IPN_IDLE:             link_octet_out <= 8'hFF;
        default:              link_octet_out <= `IPN_OCT_IDLE;
      endcase
    end
  end

  ack_drop_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    wb_ack_out |=> !wb_ack_out) else $error("ack held twice");
  resync_off_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    state_r == IPN_RESYNC |=> !link_s_on_out && !link_x_on_out) else $error("resync status wrong");
  noexch_on_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    state_r == IPN_NOEXCH |=> link_s_on_out && link_x_on_out) else $error("no-exchange status wrong");
  fill_oct_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    state_r == IPN_FILL |=> link_octet_out == `IPN_OCT_FILL) else $error("fill octet missing");
  ready_flag_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (state_r == IPN_READY && link_take_in && !ctrl_r[`IPN_CTRL_DISC]) |=> reentry_r) else $error("flag not set");
  clear_out_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    state_r == IPN_CLEAR |=> link_clear_out) else $error("clear not driven");
  c_data: cover property (@(posedge clk_in) state_r == IPN_DATA);
  c_swap: cover property (@(posedge clk_in) state_r == IPN_FILL ##1 state_r == IPN_XBEGIN);
  c_resync: cover property (@(posedge clk_in) state_r == IPN_RESYNC ##1 state_r == IPN_NOEXCH);
endmodule // ipn_ctrl

// ===== tb/ipn_peer.sv
// peer adaptor model on the far side of the octet link
`timescale 1ns/1ps
`include "ipn_defines.svh"
module ipn_peer (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       orig_in,
  input  wire logic       slow_in,
  input  wire logic [7:0] dut_oct_in,
  output logic            take_out,
  output logic [7:0]      oct_out,
  output logic            stb_out,
  output logic            done_out
);
  logic [2:0] st_r;
  logic [7:0] last_r;
  logic [5:0] run_r;
  logic [7:0] idx_r;
  logic       ph_r;
  logic [7:0] nxt;
  logic [7:0] g;
  logic [7:0] pos;
  logic       seen;
  assign done_out = (st_r == 3'd5);
  assign seen = (run_r >= 6'd4);
  // consume at full or half pace and count identical runs
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      take_out <= 1'b0;
      run_r    <= 6'd0;
      last_r   <= 8'hFF;
    end else begin
      take_out <= slow_in ? !take_out : 1'b1;
      if (take_out) begin
        last_r <= dut_oct_in;
        run_r  <= (dut_oct_in != last_r) ? 6'd1 : (run_r == 6'd63) ? run_r : run_r + 6'd1;
      end
    end
  end
  // own block: run of 32 commands, then three low-high pairs, six groups
  always_comb begin
    g   = idx_r / 8'd38;
    pos = idx_r % 8'd38;
    case (st_r)
      3'd1: nxt = `IPN_OCT_XBEGIN;
      3'd2: begin
        if (pos < 8'd32) nxt = (g == 8'd0) ? `IPN_OCT_VERSION : 8'(`IPN_OCT_SET0 + g - 8'd1);
        else nxt = pos[0] ? (`IPN_OCT_HIGH | 8'h01) : (`IPN_OCT_LOW | g);
      end
      3'd3: nxt = `IPN_OCT_FILL;
      3'd4: nxt = `IPN_OCT_READY;
      default: nxt = 8'hFF;
    endcase
  end
  // one octet every other cycle; a changing pattern between strobes
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      ph_r    <= 1'b0;
      stb_out <= 1'b0;
      oct_out <= 8'h00;
      st_r    <= 3'd0;
      idx_r   <= 8'd0;
    end else begin
      ph_r    <= !ph_r;
      stb_out <= ph_r && st_r != 3'd0 && st_r != 3'd5;
      oct_out <= (ph_r && st_r != 3'd0 && st_r != 3'd5) ? nxt : ~oct_out;
      case (st_r)
        3'd0: begin
          if (orig_in) st_r <= 3'd1;
          else if (seen && last_r == `IPN_OCT_XBEGIN) st_r <= 3'd2;
        end
        3'd1: if (seen && last_r == `IPN_OCT_VERSION) st_r <= 3'd2;
        3'd2: begin
          if (ph_r) idx_r <= idx_r + 8'd1;
          if (ph_r && idx_r == 8'd227) st_r <= 3'd3;
        end
        3'd3: begin
          if (!orig_in && seen && last_r == `IPN_OCT_FILL) st_r <= 3'd4;
          idx_r <= 8'd0;
        end
        3'd4: begin
          if (ph_r) idx_r <= idx_r + 8'd1;
          if (ph_r && idx_r == 8'd31) st_r <= 3'd5;
        end
        default: st_r <= st_r;
      endcase
    end
  end
endmodule // ipn_peer

// ===== tb/tb.sv
// self-checking bench for the negotiation controller
`timescale 1ns/1ps
`include "ipn_defines.svh"
`define CHK(a, e, m) begin n_tests++; if ((a) !== (e)) begin n_fail++; $display("CHECK FAILED t=%0t %s", $time, m); end end
module tb;
  import ipn_pkg::*;
  localparam int T1C = 3000;
  localparam int T2C = 1500;
  typedef struct {logic calling; logic porig; logic [7:0] first; logic orig;} ipn_row_s;
  logic        clk_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic        peer_rst_n = 1'b0;
  logic        cyc = 1'b0;
  logic        we = 1'b0;
  logic [3:0]  adr = 4'h0;
  logic [31:0] dat = 32'h0;
  logic        sync = 1'b0;
  logic        s_on = 1'b0;
  logic        x_on = 1'b0;
  logic        slow = 1'b0;
  logic        porig = 1'b0;
  logic [31:0] rdat, q;
  logic        ack, take, p_stb, p_done, clr, dflt, s_out, x_out;
  logic [7:0]  oct_out, p_oct;
  logic [7:0]  outq[$];
  ipn_row_s    rows[2];
  time         t_pv, t_dv, t_fl;
  int          n_fail = 0;
  int          n_tests = 0;
  int          n;
  // bench clock, 100 ns period
  always #50 clk_in = ~clk_in;
  ipn_ctrl #(.T1_CYC(T1C), .T2_CYC(T2C)) uut (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .wb_cyc_in(cyc), .wb_stb_in(cyc), .wb_we_in(we),
    .wb_adr_in(adr), .wb_dat_in(dat), .wb_sel_in(4'hF), .wb_dat_out(rdat), .wb_ack_out(ack),
    .link_octet_in(p_oct), .link_octet_stb_in(p_stb), .link_take_in(take), .link_sync_in(sync),
    .link_s_on_in(s_on), .link_x_on_in(x_on), .link_octet_out(oct_out), .link_s_on_out(s_out),
    .link_x_on_out(x_out), .link_clear_out(clr), .link_default_out(dflt));
  ipn_peer peer (
    .clk_in(clk_in), .rst_n_in(peer_rst_n), .orig_in(porig), .slow_in(slow), .dut_oct_in(oct_out),
    .take_out(take), .oct_out(p_oct), .stb_out(p_stb), .done_out(p_done));
  // record every negotiation octet the peer consumes and key moments; idle fill is skipped
  always @(posedge clk_in) begin
    if (take && oct_out !== 8'hFF && oct_out !== `IPN_OCT_IDLE) begin
      outq.push_back(oct_out);
      if (oct_out === `IPN_OCT_VERSION && t_dv == 0) t_dv = $time;
      if (oct_out === `IPN_OCT_FILL && t_fl == 0) t_fl = $time;
    end
    if (p_stb && p_oct === `IPN_OCT_VERSION && t_pv == 0) t_pv = $time;
  end
  // classic single wishbone cycle, waits for ack
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    cyc <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    @(posedge clk_in);
    while (ack !== 1'b1 && k < 20) begin
      @(posedge clk_in);
      k++;
    end
    q = rdat;
    cyc <= 1'b0;
    we  <= 1'b0;
    @(posedge clk_in);
    `CHK(k < 20, 1'b1, "no bus ack")
  endtask
  task automatic do_reset(input logic peer_on);
    rst_n_in <= 1'b0;
    peer_rst_n <= 1'b0;
    sync <= 1'b1;
    s_on <= 1'b0;
    x_on <= 1'b0;
    repeat (10) @(posedge clk_in);
    outq.delete();
    t_pv = 0;
    t_dv = 0;
    t_fl = 0;
    rst_n_in <= 1'b1;
    peer_rst_n <= peer_on;
    @(posedge clk_in);
    wb(1'b1, `IPN_REG_PARAM_LO, 32'h5A3C0010);
    wb(1'b1, `IPN_REG_PARAM_HI, 32'h00000016);
  endtask
  // poll status until the state field reaches st
  task automatic wait_state(input ipn_state_e st, input int lim);
    int k;
    for (k = 0; k < lim; k++) begin
      wb(1'b0, `IPN_REG_STATUS, 32'h0);
      if (q[3:0] === st) break;
    end
  endtask
  task automatic check_stream();
    int p, r, g, k;
    logic [7:0] c, v;
    logic [7:0] ev[6] = '{8'h10, 8'h00, 8'h3C, 8'h5A, 8'h16, 8'h16};
    p = 0;
    while (p < outq.size() && outq[p] === `IPN_OCT_XBEGIN) p++;
    `CHK(p >= 32, 1'b1, "short begin run")
    for (g = 0; g < 6; g++) begin
      c = (g == 0) ? `IPN_OCT_VERSION : 8'(`IPN_OCT_SET0 + g - 1);
      r = 0;
      while (p < outq.size() && outq[p] === c) begin
        p++;
        r++;
      end
      `CHK(r >= 32, 1'b1, "short or misordered command run")
      for (k = 0; k < 6; k++) begin
        v = outq[p + k];
        `CHK(v[7:4], k[0] ? 4'hB : 4'hA, "low-high order")
        `CHK(v[3:0], k[0] ? ev[g][7:4] : ev[g][3:0], "pair value")
      end
      p = p + 6;
    end
    `CHK(outq[p], `IPN_OCT_FILL, "no padding after block")
    `CHK(t_dv > t_pv, 1'b1, "version sent before peer version")
    `CHK(t_fl - t_dv < T2C * 100, 1'b1, "block too slow")
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // watchdog
  initial begin
    repeat (40000) @(posedge clk_in);
    n_fail++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    wrap_up();
  end
  initial begin
    rows[0] = '{1'b1, 1'b0, `IPN_OCT_XBEGIN, 1'b1};
    rows[1] = '{1'b0, 1'b1, `IPN_OCT_VERSION, 1'b0};
    do_reset(1'b1);
    wb(1'b0, `IPN_REG_STATUS, 32'h0);
    `CHK(q, 32'h0, "status after reset")
    `CHK(oct_out, 8'hFF, "idle octet after reset")
    wb(1'b0, 4'h2, 32'h0);
    `CHK(q, 32'h0, "unmapped read")
    // role table: caller originates, called answers
    foreach (rows[i]) begin
      porig <= rows[i].porig;
      do_reset(1'b1);
      wb(1'b1, `IPN_REG_CTRL, {29'h0, 1'b1, rows[i].calling, 1'b1});
      n = 0;
      while (outq.size() == 0 && n < 300) begin
        @(posedge clk_in);
        n++;
      end
      `CHK(outq[0], rows[i].first, "first octet of role")
      wb(1'b0, `IPN_REG_STATUS, 32'h0);
      `CHK(q[5], rows[i].orig, "role flag")
    end
    // full exchange as caller against a slow consuming peer
    porig <= 1'b0;
    slow <= 1'b1;
    do_reset(1'b1);
    wb(1'b1, `IPN_REG_CTRL, 32'h00000007);
    n = 0;
    while (p_done !== 1'b1 && n < 4000) begin
      @(posedge clk_in);
      n++;
    end
    wait_state(IPN_DATA, 100);
    `CHK(q[3:0], IPN_DATA, "no data transfer after ready")
    `CHK(q[6], 1'b1, "re-entry flag")
    check_stream();
    wb(1'b1, `IPN_REG_CTRL, 32'h00000010);
    n = 0;
    while (clr !== 1'b1 && n < 50) begin
      @(posedge clk_in);
      n++;
    end
    `CHK(clr, 1'b1, "disconnect not cleared")
    // silent peer: timers fall back to defaults
    slow <= 1'b0;
    do_reset(1'b0);
    wb(1'b1, `IPN_REG_CTRL, 32'h00000003);
    n = 0;
    while (dflt !== 1'b1 && n < T1C + 200) begin
      @(posedge clk_in);
      n++;
    end
    `CHK(dflt, 1'b1, "no default fallback")
    // both status lines on: straight to data
    do_reset(1'b0);
    sync <= 1'b1;
    s_on <= 1'b1;
    x_on <= 1'b1;
    wb(1'b1, `IPN_REG_CTRL, 32'h00000001);
    wait_state(IPN_DATA, 100);
    `CHK(q[3:0], IPN_DATA, "status on not skipping exchange")
    `CHK({s_out, x_out}, 2'b11, "status lines not on in data")
    wrap_up();
  end
endmodule // tb
